// >>> logic/msc_channel.sv
// one serial / bit-bang channel with flush timer and reset output
//
// Local design decisions: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
// How it works
// (RULE1) flush timeout settable 1 to 255 ms
// (RULE2) prescaler divides by n plus eighths
// (RULE3) bit-bang turns data lines into IO port
// (RULE4) async bit-bang paces bytes by rate timer
// (RULE5) enhanced bit-bang exports read/write strobes
// (RULE6) sync bit-bang samples only on output write
// (RULE7) serial frames with seven or eight bits
// (RULE8) modem control and status lines provided
// (RULE9) line driver enable while transmitting
// (RULE10) hardware RTS/CTS, DSR/DTR, XON/XOFF flow
// (RULE11) send break and detect received break
// (RULE12) working clock is reference times eight
// (RULE13) reset output floats about 5 ms first
// (RULE14) external reset low forces reset output low
// (RULE15) bus reset leaves reset output alone
// (RULE16) external reset input may stay unconnected
// (RULE17) config selects serial or FIFO modes
// (RULE18) config holds wakeup, iso, pulldown, descriptor
// (RULE19) usb 2.0 descriptor at full speed
// (RULE20) switched supply only after enumeration
// (RULE21) bus emulation joins both channels' buses
// (RULE22) peripheral paces isolated four-wire link
// (RULE23) send-now strobe flushes receive buffer
// (RULE24) each channel keeps independent state
module msc_channel #(
    parameter int MS_CYCLES = msc_pkg::MS_CYC,
    parameter int RST_HOLD_CYCLES = msc_pkg::RST_HOLD_CYC
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_out,
    output logic wr_strobe_n_out,
    output logic rd_strobe_n_out,
    output logic line_driver_enable_out,
    input wire logic send_now_wake_n_in,
    input wire logic usb_suspended_in,
    input wire logic usb_configured_in,
    input wire logic usb_bus_reset_in,
    output logic rx_flush_out,
    output logic wake_request_out,
    output logic switched_supply_out,
    input wire logic ext_reset_in_n,
    output logic reset_out_n_out,
    output logic reset_out_n_oe_out,
    output logic [6:0] cfg_out,
    output logic [15:0] desc_version_out
);
    // all state; instances share nothing [RULE24]
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        msc_pkg::msc_mode_t mode;
        msc_pkg::msc_flow_t flow;
        logic data7;
        logic brk;
        logic rts;
        logic dtr;
        logic [6:0] cfg;
        logic [14:0] div_int;
        logic [2:0] div_frac;
        logic [7:0] tmo;
        logic [7:0] dir;
        logic [7:0] txh;
        logic txh_v;
        logic [7:0] rxh;
        logic rxh_v;
        logic ovr;
        logic brk_det;
        logic flush;
        logic xoff;
        logic tx_busy;
        logic [3:0] txs;
        logic [3:0] txbits;
        logic [9:0] txsh;
        msc_pkg::msc_rx_t rxst;
        logic [3:0] rxs;
        logic [3:0] rxbit;
        logic [7:0] rxsh;
        logic [7:0] pout;
        logic [7:0] oe;
        logic wr_p;
        logic rd_p;
        logic flush_p;
        logic wake_p;
        logic sn_prev;
        logic [15:0] mscnt;
        logic [7:0] mselap;
        logic [15:0] rstcnt;
        logic rst_done;
        logic rout;
        logic roe;
        logic sw;
    } msc_st_t;

    msc_st_t q;
    msc_st_t d;
    msc_st_t keep;
    logic tick;
    logic acc_wr;
    logic acc_rd;
    logic [31:0] ctrl_word;
    logic [31:0] stat_word;
    logic [31:0] rv;
    logic [31:0] w;
    logic tx_ok;
    logic txd;
    logic rx_new;
    logic [7:0] rx_byte;
    logic [7:0] tmo_eff;
    logic [3:0] nbits;

    msc_rate_if rate ();

    function automatic msc_st_t msc_init();
        msc_st_t s;
        s = '0;
        s.div_int = msc_pkg::DIV_RST;
        s.tmo = msc_pkg::TMO_RST;
        s.sn_prev = 1'b1;
        s.rout = 1'b1;
        return s;
    endfunction

    function automatic logic [31:0] msc_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] be);
        logic [31:0] r;
        for (int i = 0; i < 4; i++) begin
            r[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
        return r;
    endfunction

    // rate timer: uart at 16 ticks a bit, bit-bang pacing [RULE12]
    msc_prescaler u_pre (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .rate(rate)
    );

    assign rate.div_int = q.div_int;
    assign rate.div_frac = q.div_frac;
    assign rate.run = (q.mode != msc_pkg::MODE_FIFO);
    assign tick = rate.tick;

    assign ctrl_word = {17'h0_0000, q.cfg, q.dtr, q.rts, q.brk, q.data7, q.flow, q.mode};
    // modem status lines are active low at the pins [RULE8]
    assign stat_word = {20'h0_0000, q.rst_done, ~pin_in[7], ~pin_in[6], ~pin_in[5], ~pin_in[3],
                        q.xoff, q.flush, q.brk_det, q.ovr, q.rxh_v, q.txh_v, q.tx_busy};

    always_comb begin
        d = q;
        keep = q;
        rx_new = 1'b0;
        rx_byte = 8'h00;
        w = 32'h0000_0000;
        acc_wr = q.ack & avs_write_in;
        acc_rd = q.ack & avs_read_in;
        tmo_eff = (q.tmo == 8'h00) ? 8'h01 : q.tmo;
        nbits = q.data7 ? 4'h6 : 4'h7;
        d.wr_p = 1'b0;
        d.rd_p = 1'b0;
        d.flush_p = 1'b0;
        d.wake_p = 1'b0;

        // answer one cycle after the request
        d.ack = (avs_read_in | avs_write_in) & !q.ack;
        case (avs_address_in)
            msc_pkg::OFF_CTRL: rv = ctrl_word;
            msc_pkg::OFF_DIV: rv = {13'h0000, q.div_frac, 1'b0, q.div_int};
            msc_pkg::OFF_TMO: rv = {24'h00_0000, q.tmo};
            msc_pkg::OFF_DIR: rv = {24'h00_0000, q.dir};
            msc_pkg::OFF_TXD: rv = {24'h00_0000, q.txh};
            msc_pkg::OFF_RXD: rv = {24'h00_0000, q.rxh};
            msc_pkg::OFF_STAT: rv = stat_word;
            default: rv = 32'h0000_0000;
        endcase
        d.rdata = rv;

        if (acc_wr) begin
            w = msc_merge(rv, avs_writedata_in, avs_byteenable_in);
            case (avs_address_in)
                msc_pkg::OFF_CTRL: begin
                    // mode and stored config [RULE17] [RULE18]
                    d.mode = msc_pkg::msc_mode_t'(w[1:0]);
                    d.flow = msc_pkg::msc_flow_t'(w[msc_pkg::C_FLOW +: 2]);
                    d.data7 = w[msc_pkg::C_DATA7];
                    d.brk = w[msc_pkg::C_BRK];
                    d.rts = w[msc_pkg::C_RTS];
                    d.dtr = w[msc_pkg::C_DTR];
                    d.cfg = w[msc_pkg::C_CFG +: msc_pkg::CFG_W];
                end
                msc_pkg::OFF_DIV: begin
                    d.div_int = w[14:0]; // [RULE2]
                    d.div_frac = w[msc_pkg::D_FRAC +: 3];
                end
                msc_pkg::OFF_TMO: d.tmo = w[7:0]; // [RULE1]
                msc_pkg::OFF_DIR: d.dir = w[7:0]; // [RULE3]
                msc_pkg::OFF_TXD: begin
                    // full holding register refuses
                    if (avs_byteenable_in[0] && !q.txh_v) begin
                        d.txh = avs_writedata_in[7:0];
                        d.txh_v = 1'b1;
                    end
                end
                msc_pkg::OFF_STAT: begin
                    if (avs_byteenable_in[0]) begin
                        d.ovr = q.ovr & !avs_writedata_in[msc_pkg::S_OVR];
                        d.brk_det = q.brk_det & !avs_writedata_in[msc_pkg::S_BRK];
                        d.flush = q.flush & !avs_writedata_in[msc_pkg::S_FLUSH];
                    end
                end
                default: begin
                end
            endcase
        end
        if (acc_rd && avs_address_in == msc_pkg::OFF_RXD) begin
            d.rxh_v = 1'b0;
        end

        // flow permission, checked at frame start [RULE10]
        tx_ok = 1'b1;
        case (q.flow)
            msc_pkg::FLOW_RTSCTS: tx_ok = !pin_in[3];
            msc_pkg::FLOW_DTRDSR: tx_ok = !pin_in[5];
            msc_pkg::FLOW_XON: tx_ok = !q.xoff;
            default: tx_ok = 1'b1;
        endcase

        case (q.mode)
            msc_pkg::MODE_SERIAL: begin
                // tx: start, data, one stop, 16 ticks each [RULE7]
                if (!q.tx_busy) begin
                    if (tick && q.txh_v && tx_ok) begin
                        d.tx_busy = 1'b1;
                        d.txsh = q.data7 ? {2'b11, q.txh[6:0], 1'b0} : {1'b1, q.txh, 1'b0};
                        d.txbits = q.data7 ? 4'h9 : 4'ha;
                        d.txs = 4'h0;
                        d.txh_v = 1'b0;
                    end
                end else if (tick) begin
                    d.txs = q.txs + 4'h1;
                    if (q.txs == msc_pkg::OVS_LAST) begin
                        d.txsh = {1'b1, q.txsh[9:1]};
                        d.txbits = q.txbits - 4'h1;
                        if (q.txbits == 4'h1) begin
                            d.tx_busy = 1'b0;
                        end
                    end
                end
                // receiver samples mid-bit from the start edge [RULE7]
                if (tick) begin
                    d.rxs = q.rxs + 4'h1;
                    case (q.rxst)
                        msc_pkg::RX_IDLE: begin
                            d.rxs = 4'h0;
                            if (!pin_in[1]) begin
                                d.rxst = msc_pkg::RX_START;
                            end
                        end
                        msc_pkg::RX_START: begin
                            if (q.rxs == msc_pkg::OVS_MID) begin
                                d.rxs = 4'h0;
                                d.rxbit = 4'h0;
                                d.rxst = pin_in[1] ? msc_pkg::RX_IDLE : msc_pkg::RX_DATA;
                            end
                        end
                        msc_pkg::RX_DATA: begin
                            if (q.rxs == msc_pkg::OVS_LAST) begin
                                d.rxsh = {pin_in[1], q.rxsh[7:1]};
                                d.rxbit = q.rxbit + 4'h1;
                                if (q.rxbit == nbits) begin
                                    d.rxst = msc_pkg::RX_STOP;
                                end
                            end
                        end
                        msc_pkg::RX_STOP: begin
                            if (q.rxs == msc_pkg::OVS_LAST) begin
                                d.rxst = msc_pkg::RX_IDLE;
                                rx_byte = q.data7 ? {1'b0, q.rxsh[7:1]} : q.rxsh;
                                if (!pin_in[1] && rx_byte == 8'h00) begin
                                    d.brk_det = 1'b1; // [RULE11]
                                end else if (q.flow == msc_pkg::FLOW_XON && rx_byte == msc_pkg::XOFF_CHAR) begin
                                    d.xoff = 1'b1; // [RULE10]
                                end else if (q.flow == msc_pkg::FLOW_XON && rx_byte == msc_pkg::XON_CHAR) begin
                                    d.xoff = 1'b0; // [RULE10]
                                end else begin
                                    rx_new = 1'b1;
                                end
                            end
                        end
                        default: d.rxst = msc_pkg::RX_IDLE;
                    endcase
                end
                // break holds the line low over any frame [RULE11]
                txd = q.brk ? 1'b0 : (q.tx_busy ? q.txsh[0] : 1'b1);
                // auto handshake drops while rx byte unread [RULE10] [RULE8]
                d.pout = {3'b000,
                          (q.flow == msc_pkg::FLOW_DTRDSR) ? q.rxh_v : !q.dtr,
                          1'b0,
                          (q.flow == msc_pkg::FLOW_RTSCTS) ? q.rxh_v : !q.rts,
                          1'b0, txd};
                d.oe = msc_pkg::SER_OE;
            end
            msc_pkg::MODE_ABB: begin
                // each tick reads port, writes next byte if one is held [RULE4] [RULE5]
                if (tick) begin
                    if (q.txh_v) begin
                        d.pout = q.txh;
                        d.txh_v = 1'b0;
                        d.wr_p = 1'b1;
                    end
                    rx_new = 1'b1;
                    rx_byte = pin_in;
                    d.rd_p = 1'b1;
                end
                d.oe = q.dir; // [RULE3]
            end
            msc_pkg::MODE_SBB: begin
                // port read only with an output write [RULE6] [RULE5]
                if (tick && q.txh_v) begin
                    d.pout = q.txh;
                    d.txh_v = 1'b0;
                    d.wr_p = 1'b1;
                    rx_new = 1'b1;
                    rx_byte = pin_in;
                    d.rd_p = 1'b1;
                end
                d.oe = q.dir; // [RULE3]
            end
            default: begin
                // fifo path lives outside
                d.oe = 8'h00;
            end
        endcase
        if (q.mode != msc_pkg::MODE_SERIAL) begin
            d.tx_busy = 1'b0;
            d.rxst = msc_pkg::RX_IDLE;
        end

        // new byte overwrites unread one, flags loss; set wins
        if (rx_new) begin
            d.ovr = d.ovr | q.rxh_v;
            d.rxh = rx_byte;
            d.rxh_v = 1'b1;
        end

        // flush timer counts ms while a byte is held [RULE1]
        if (!q.rxh_v || rx_new) begin
            d.mscnt = 16'h0000;
            d.mselap = 8'h00;
        end else if (q.mscnt == 16'(MS_CYCLES - 1)) begin
            d.mscnt = 16'h0000;
            if ({1'b0, q.mselap} + 9'h001 >= {1'b0, tmo_eff}) begin
                d.mselap = 8'h00;
                d.flush_p = 1'b1;
                d.flush = 1'b1;
            end else begin
                d.mselap = q.mselap + 8'h01;
            end
        end else begin
            d.mscnt = q.mscnt + 16'h0001;
        end

        // send-now: wake if suspended with wakeup enabled, else flush [RULE23] [RULE18]
        d.sn_prev = send_now_wake_n_in;
        if (q.sn_prev && !send_now_wake_n_in) begin
            if (usb_suspended_in && q.cfg[msc_pkg::CFG_WAKE]) begin
                d.wake_p = 1'b1;
            end else begin
                d.flush_p = 1'b1;
                d.flush = 1'b1;
            end
        end

        // supply switch follows enumeration only [RULE20]
        d.sw = usb_configured_in;

        // reset output floats for the hold time [RULE13]
        if (!q.rst_done) begin
            d.rstcnt = q.rstcnt + 16'h0001;
            if (q.rstcnt == 16'(RST_HOLD_CYCLES - 1)) begin
                d.rst_done = 1'b1;
            end
        end
        // ext reset holds the output low [RULE14]
        d.rout = ext_reset_in_n;
        d.roe = d.rst_done | !ext_reset_in_n;

        // bus reset drops data, not the reset output [RULE15]
        if (usb_bus_reset_in) begin
            d.txh_v = 1'b0;
            d.rxh_v = 1'b0;
            d.tx_busy = 1'b0;
            d.rxst = msc_pkg::RX_IDLE;
        end

        // ext reset reinits all but the reset generator, send-now edge flop and supply switch [RULE14]
        if (!ext_reset_in_n) begin
            keep = d;
            d = msc_init();
            d.rstcnt = keep.rstcnt;
            d.rst_done = keep.rst_done;
            d.rout = keep.rout;
            d.roe = keep.roe;
            d.sn_prev = keep.sn_prev;
            d.sw = keep.sw;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            q <= msc_init();
        end else if (ce_in) begin
            q <= d;
        end
    end

    // wait for the answer flop and clock enable
    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & !(q.ack & ce_in);
    assign avs_readdata_out = q.rdata;
    assign pin_out = q.pout;
    assign pin_oe_out = q.oe;
    assign wr_strobe_n_out = !q.wr_p; // [RULE5]
    assign rd_strobe_n_out = !q.rd_p; // [RULE5]
    assign line_driver_enable_out = q.tx_busy; // [RULE9]
    assign rx_flush_out = q.flush_p;
    assign wake_request_out = q.wake_p;
    assign switched_supply_out = q.sw;
    assign reset_out_n_out = q.rout;
    assign reset_out_n_oe_out = q.roe;
    // bit six joins the partner in bus emulation [RULE21]
    assign cfg_out = q.cfg;
    // descriptor version changes, speed stays full [RULE19]
    assign desc_version_out = q.cfg[msc_pkg::CFG_USB2] ? msc_pkg::DESC_USB20 : msc_pkg::DESC_USB11;
endmodule

// >>> logic/msc_prescaler.sv
// fractional prescaler: one tick per n plus eighths
`timescale 1ns/1ps
module msc_prescaler (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic ce_in,
    msc_rate_if.pre rate
);
    typedef struct packed {
        logic [14:0] cnt;
        logic [2:0] acc;
        logic tick;
    } msc_pre_st_t;
    msc_pre_st_t q;
    msc_pre_st_t d;
    logic [14:0] n;
    logic [3:0] sum;

    always_comb begin
        d = q;
        n = rate.div_int;
        if (rate.div_int < msc_pkg::DIV_MIN) begin
            n = msc_pkg::DIV_MIN;
        end else if (rate.div_int > msc_pkg::DIV_MAX) begin
            n = msc_pkg::DIV_MAX;
        end
        sum = {1'b0, q.acc} + {1'b0, rate.div_frac};
        d.tick = 1'b0;
        if (!rate.run) begin
            d.cnt = 15'h0000;
            d.acc = 3'h0;
        end else if (q.cnt == 15'h0000) begin
            // each eighths carry adds a cycle [RULE2]
            d.tick = 1'b1;
            d.acc = sum[2:0];
            d.cnt = n - 15'h0001 + {14'h0000, sum[3]};
        end else begin
            d.cnt = q.cnt - 15'h0001;
        end
    end

    assign rate.tick = q.tick;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            q <= '0;
        end else if (ce_in) begin
            q <= d;
        end
    end
endmodule

// >>> shared/msc_pkg.sv
// package: constants and types for the multimode serial channel
package msc_pkg;
    // core clock is reference times eight
    localparam int CLK_HZ = 10_000_000;
    localparam int REF_HZ = 6_000_000;
    localparam int PLL_MULT = 8;
    localparam int CORE_HZ = REF_HZ * PLL_MULT;
    localparam int MS_TIME_US = 1000;
    localparam int RST_HOLD_US = 5000;
    localparam int MS_CYC = (CLK_HZ / 1_000_000) * MS_TIME_US;
    localparam int RST_HOLD_CYC = (CLK_HZ / 1_000_000) * RST_HOLD_US;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DIV = 8'h04;
    localparam logic [7:0] OFF_TMO = 8'h08;
    localparam logic [7:0] OFF_DIR = 8'h0c;
    localparam logic [7:0] OFF_TXD = 8'h10;
    localparam logic [7:0] OFF_RXD = 8'h14;
    localparam logic [7:0] OFF_STAT = 8'h18;
    // control field positions
    localparam int C_FLOW = 2;
    localparam int C_DATA7 = 4;
    localparam int C_BRK = 5;
    localparam int C_RTS = 6;
    localparam int C_DTR = 7;
    localparam int C_CFG = 8;
    localparam int CFG_W = 7;
    localparam int CFG_WAKE = 0;
    localparam int CFG_USB2 = 3;
    localparam int D_FRAC = 16;
    // status field positions (write one to clear)
    localparam int S_OVR = 3;
    localparam int S_BRK = 4;
    localparam int S_FLUSH = 5;
    // reset values and fixed codes
    localparam logic [14:0] DIV_RST = 15'h001a;
    localparam logic [14:0] DIV_MIN = 15'h0002;
    localparam logic [14:0] DIV_MAX = 15'h4000;
    localparam logic [7:0] TMO_RST = 8'h10;
    localparam logic [7:0] XON_CHAR = 8'h11;
    localparam logic [7:0] XOFF_CHAR = 8'h13;
    localparam logic [7:0] SER_OE = 8'h15;
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] OVS_MID = 4'h7;
    localparam logic [15:0] DESC_USB11 = 16'h0110;
    localparam logic [15:0] DESC_USB20 = 16'h0200;
    typedef enum logic [1:0] {
        MODE_SERIAL = 2'b00, MODE_ABB = 2'b01, MODE_SBB = 2'b10, MODE_FIFO = 2'b11
    } msc_mode_t;
    typedef enum logic [1:0] {
        FLOW_NONE = 2'b00, FLOW_RTSCTS = 2'b01, FLOW_DTRDSR = 2'b10, FLOW_XON = 2'b11
    } msc_flow_t;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10, RX_STOP = 2'b11
    } msc_rx_t;
endpackage

// >>> shared/msc_rate_if.sv
// interface: divisor settings and rate tick between channel and prescaler
`timescale 1ns/1ps
interface msc_rate_if;
    logic [14:0] div_int;
    logic [2:0] div_frac;
    logic run;
    logic tick;
    modport pre (input div_int, input div_frac, input run, output tick);
    modport user (output div_int, output div_frac, output run, input tick);
endinterface

// >>> test/msc_monitor.sv
// checker: port timing properties of the channel
`timescale 1ns/1ps
module msc_monitor #(parameter int RST_HOLD_CYCLES = 30) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic ext_reset_in_n,
    input wire logic reset_out_n_out,
    input wire logic reset_out_n_oe_out,
    input wire logic usb_configured_in,
    input wire logic usb_bus_reset_in,
    input wire logic switched_supply_out,
    input wire logic line_driver_enable_out,
    input wire logic [7:0] pin_out,
    input wire logic wr_strobe_n_out,
    input wire logic send_now_wake_n_in,
    input wire logic usb_suspended_in,
    input wire logic rx_flush_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // saturating age since reset release
    logic [15:0] age_q;
    always_ff @(posedge clock_in) begin
        age_q <= rst_in ? 16'h0000 : (age_q == 16'hffff ? age_q : age_q + 16'h0001);
    end
    a_ext_rst_low: assert property (!ext_reset_in_n |=> !reset_out_n_out && reset_out_n_oe_out)
        else $error("reset output not forced low");
    a_bus_rst_keep: assert property (usb_bus_reset_in && ext_reset_in_n |=> reset_out_n_out)
        else $error("bus reset reached reset output");
    a_supply_after_enum: assert property (!usb_configured_in |=> !switched_supply_out)
        else $error("supply on before enumeration");
    a_rst_out_float: assert property (age_q < RST_HOLD_CYCLES |-> !reset_out_n_oe_out)
        else $error("reset output driven too early");
    a_rst_out_drive: assert property (age_q == RST_HOLD_CYCLES + 2 |-> reset_out_n_oe_out)
        else $error("reset output still floating");
    a_ldr_frame_start: assert property ($rose(line_driver_enable_out) |=> !pin_out[0])
        else $error("line driver enable not with start bit");
    a_wr_strobe_pulse: assert property (!wr_strobe_n_out |=> wr_strobe_n_out)
        else $error("write strobe longer than one cycle");
    a_send_now_flush: assert property ($fell(send_now_wake_n_in) && !usb_suspended_in && ext_reset_in_n
        |=> rx_flush_out) else $error("send-now strobe gave no flush");
    c_frame: cover property ($rose(line_driver_enable_out));
    c_flush: cover property (rx_flush_out);
    c_strobe: cover property (!wr_strobe_n_out);
endmodule
bind msc_channel msc_monitor #(.RST_HOLD_CYCLES(RST_HOLD_CYCLES)) mon (.*);

// >>> test/msc_partner.sv
// partner: far-side pin logic and serial sender
`timescale 1ns/1ps
module msc_partner (
    input wire logic clock_in,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_out,
    output logic [7:0] pin_in
);
    logic [7:0] far_q = 8'hff;
    // driven pins read back, others the far side
    assign pin_in = (pin_oe_out & pin_out) | (~pin_oe_out & far_q);
    task automatic send(input logic [7:0] b, input int bit_cyc);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            far_q[1] <= fr[i];
            repeat (bit_cyc) @(posedge clock_in);
        end
    endtask
endmodule

// >>> test/testbench.sv
// testbench: bus, serial, bit-bang and reset checks
`timescale 1ns/1ps
module testbench;
    logic clock_in = 0, rst_in = 1, rd = 0, wr = 0, snw = 1, cfgd = 0, busrst = 0, ext_n = 1;
    logic [7:0] adr = 8'h00, pin_in, pin_out, pin_oe, b, f1;
    logic [31:0] wd = 32'h0000_0000, rdat, q, seed = 32'h0000_002f;
    logic [9:0] s;
    logic waitreq, wrs_n, rds_n, ldr, flush;
    int n_fail = 0, n_checks = 0, cyc = 0, n;
    msc_channel #(.MS_CYCLES(20), .RST_HOLD_CYCLES(30)) uut (.clock_in, .rst_in, .ce_in(1'b1),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_byteenable_in(4'hf), .avs_readdata_out(rdat), .avs_waitrequest_out(waitreq), .pin_in,
        .pin_out, .pin_oe_out(pin_oe), .wr_strobe_n_out(wrs_n), .rd_strobe_n_out(rds_n),
        .line_driver_enable_out(ldr), .send_now_wake_n_in(snw), .usb_suspended_in(1'b0),
        .usb_configured_in(cfgd), .usb_bus_reset_in(busrst), .rx_flush_out(flush), .wake_request_out(),
        .switched_supply_out(), .ext_reset_in_n(ext_n), .reset_out_n_out(), .reset_out_n_oe_out(),
        .cfg_out(), .desc_version_out());
    msc_partner p (.clock_in, .pin_out, .pin_oe_out(pin_oe), .pin_in);
    initial forever #50 clock_in = ~clock_in;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // frame clocks: bits of 16 ticks of 2 plus eighths
    function automatic int len(int f, logic s7);
        return (10 - s7) * (32 + 2 * f);
    endfunction
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // idle cycle between transfers
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        adr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        do @(posedge clock_in); while (waitreq);
        q = rdat;
        rd <= 0;
        wr <= 0;
        @(posedge clock_in);
    endtask
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        repeat (20) @(posedge clock_in);
        rst_in <= 0;
        @(posedge clock_in);
        bus(0, 8'h04, 0);
        chk(q, 32'h0000_001a);
        bus(0, 8'h08, 0);
        chk(q, 32'h0000_0010);
        bus(0, 8'h1c, 0);
        chk(q, 32'h0000_0000);
        for (int f = 0; f < 8; f++) begin
            b = 8'(rnd());
            bus(1, 8'h00, {27'h0, f[0], 4'h0});
            bus(1, 8'h04, {13'h0, f[2:0], 16'h0002});
            bus(1, 8'h10, {24'h0, b});
            while (!ldr) @(posedge clock_in);
            n = 0;
            s = 0;
            while (ldr) begin
                if (n % (32 + 2 * f) == 16 + f) s = {pin_out[0], s[9:1]};
                n++;
                @(posedge clock_in);
            end
            chk(n, len(f, f[0]));
            chk(s >> f[0], f[0] ? {2'b01, b[6:0], 1'b0} : {1'b1, b, 1'b0});
        end
        bus(1, 8'h00, 0);
        bus(1, 8'h04, 32'h0000_0002);
        bus(1, 8'h08, 32'h0000_0003);
        b = 8'(rnd());
        p.send(b, 32);
        while (!flush) @(posedge clock_in);
        @(posedge clock_in);
        n = 1;
        while (!flush) begin
            n++;
            @(posedge clock_in);
        end
        chk(n, 3 * 20);
        bus(0, 8'h14, 0);
        chk(q, {24'h0, b});
        bus(1, 8'h0c, 32'h0000_000f);
        bus(1, 8'h00, 32'h0000_0002);
        n = 0;
        repeat (40) begin
            @(posedge clock_in);
            n += !rds_n;
        end
        chk(n, 0);
        chk(pin_oe, 8'h0f);
        f1 = 8'(rnd());
        b = 8'(rnd());
        p.far_q <= f1;
        bus(1, 8'h10, {24'h0, b});
        while (wrs_n) @(posedge clock_in);
        p.far_q <= ~f1;
        bus(1, 8'h10, {24'h0, ~b});
        while (wrs_n) @(posedge clock_in);
        bus(0, 8'h14, 0);
        chk(q[7:0], {~f1[7:4], b[3:0]});
        snw <= 0;
        @(posedge clock_in);
        snw <= 1;
        cfgd <= 1;
        busrst <= 1;
        repeat (2) @(posedge clock_in);
        busrst <= 0;
        ext_n <= 0;
        repeat (3) @(posedge clock_in);
        ext_n <= 1;
        repeat (5) @(posedge clock_in);
        conclude();
    end
endmodule
